/* File: logic/ddci_top.sv */
// disk drive controller: select, step, head, gates, data
// assumes drive pins asynchronous; read clock from the drive
module ddci_top
  import ddci_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        CE,
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  input  wire logic        READY,
  input  wire logic        SEEK_DONE,
  input  wire logic        WRITE_FAULT,
  input  wire logic        RD_CLK,
  input  wire logic        RD_NRZ,
  output logic      [2:0]  DRV_SEL,
  output logic             STEP,
  output logic             DIRECTION,
  output logic      [3:0]  HEAD_SEL,
  output logic             WRITE_GATE,
  output logic             WRITE_DATA,
  output logic             RECOVERY,
  output logic             READ_GATE
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // unit number to one select line, none for unit 0
  function automatic logic [2:0] unit_dec(input logic [1:0] u);
    unit_dec = (u == 2'h0) ? 3'h0 : 3'(3'h1 << (u - 2'h1));
  endfunction : unit_dec
  // bit period for the chosen variant
  function automatic logic [2:0] bit_cyc(input logic [1:0] m);
    case (m)
      MODE_BASE: bit_cyc = BASE_BIT_CYC;
      MODE_HP:   bit_cyc = HP_BIT_CYC;
      default:   bit_cyc = SEP_BIT_CYC;
    endcase
  endfunction : bit_cyc
  // ----------------------------------------------------------------
  // pin and link crossings
  // ----------------------------------------------------------------
  logic ready_s, sdone_s, wf_s; // drive status, synced
  logic req_s, ovr_s;           // read handshake, synced
  logic [7:0] hold;             // link byte, stable by handshake
  logic req_l, ovr_l;           // link side flags
  logic ack_r, ack_nxt;         // acknowledge toggle
  ddci_sync #(.W(5)) u_sync (
    .clk   (CLK),
    .rst_n (RESET_N),
    .en    (CE),
    .d     ({READY, SEEK_DONE, WRITE_FAULT, req_l, ovr_l}),
    .q     ({ready_s, sdone_s, wf_s, req_s, ovr_s})
  );
  ddci_rx u_rx (
    .rd_clk  (RD_CLK),
    .rst_n   (RESET_N),
    .nrz     (RD_NRZ),
    .gate    (READ_GATE),
    .ack_tgl (ack_r),
    .hold_r  (hold),
    .req_r   (req_l),
    .ovr_r   (ovr_l)
  );
  // ----------------------------------------------------------------
  // control, recovery and read capture registers
  // ----------------------------------------------------------------
  logic [1:0] unit_r, unit_nxt;   // chosen drive
  logic [3:0] head_r, head_nxt;   // head index
  logic [1:0] mode_r, mode_nxt;   // interface variant
  logic       wgq_r, wgq_nxt;     // write window request
  logic       rgq_r, rgq_nxt;     // read window request
  logic       rec_r, rec_nxt;     // recovery mode
  logic [3:0] tries_r, tries_nxt; // recovery steps issued
  logic       abn_r, abn_nxt;     // recovery abandoned
  logic       wfs_r, wfs_nxt;     // sticky write fault
  logic       ref_r, ref_nxt;     // sticky refused seek
  logic [7:0] rxd_r, rxd_nxt;     // last read byte
  logic       rxv_r, rxv_nxt;     // read byte waiting
  logic       go;                 // start a step train
  logic [7:0] go_cnt;             // pulses to issue
  logic       go_dir;             // direction for that train
  logic       busy;               // step train running
  logic       wg_ok;              // write window permitted
  logic       step_ok;            // step train permitted
  logic       wr_ctrl, wr_seek, wr_rec;
  assign wr_ctrl = WR && ADDR == A_CTRL;
  assign wr_seek = WR && ADDR == A_SEEK;
  assign wr_rec  = WR && ADDR == A_RECOV;
  // step prerequisites, checked at the start of a train
  assign step_ok = !WRITE_GATE && unit_r != 2'h0 &&
                   ready_s && sdone_s;
  assign wg_ok = unit_r != 2'h0 && ready_s && !wf_s &&
                 !busy;
  // control next state
  always_comb begin
    unit_nxt  = unit_r;
    head_nxt  = head_r;
    mode_nxt  = mode_r;
    wgq_nxt   = wgq_r;
    rgq_nxt   = rgq_r;
    rec_nxt   = rec_r;
    tries_nxt = tries_r;
    abn_nxt   = abn_r;
    wfs_nxt   = wfs_r;
    ref_nxt   = ref_r;
    rxd_nxt   = rxd_r;
    rxv_nxt   = rxv_r;
    ack_nxt   = ack_r;
    go        = 1'b0;
    go_cnt    = WDATA[7:0];
    go_dir    = WDATA[S_DIR];
    if (wr_ctrl) begin // new settings
      unit_nxt = WDATA[C_UNIT +: 2];
      head_nxt = WDATA[C_HEAD +: 4];
      mode_nxt = WDATA[C_MODE +: 2];
      wgq_nxt  = WDATA[C_WG];
      rgq_nxt  = WDATA[C_RG];
      rec_nxt  = WDATA[C_REC];
      if (WDATA[C_REC] && !rec_r) begin // fresh attempt
        tries_nxt = 4'h0;
        abn_nxt   = 1'b0;
      end
    end
    if (wr_seek) begin // plain seek
      if (step_ok && !busy && WDATA[7:0] != 8'h00)
        go = 1'b1;
      else
        ref_nxt = 1'b1;
    end
    if (wr_rec && rec_r) begin // verdict on a reread
      if (WDATA[R_OK]) begin // data recovered
        rec_nxt   = 1'b0;
        tries_nxt = 4'h0;
      end else if (WDATA[R_FAIL]) begin
        if (tries_r == MAX_TRIES) begin
          rec_nxt = 1'b0;
          abn_nxt = 1'b1;
        end else if (step_ok && !busy) begin
          go        = 1'b1;
          go_cnt    = 8'h01;
          go_dir    = DIRECTION;
          tries_nxt = tries_r + 4'h1;
        end else begin
          ref_nxt = 1'b1;
        end
      end
    end
    if (wf_s) // set wins over clear
      wfs_nxt = 1'b1;
    if (req_s != ack_r) begin // new byte from link
      rxd_nxt = hold;
      rxv_nxt = 1'b1;
      ack_nxt = req_s;
    end else if (RD && ADDR == A_RXD) begin
      rxv_nxt = 1'b0;
    end
    if (RD && ADDR == A_STAT) begin // reading clears stickies
      wfs_nxt = wf_s;
      ref_nxt = 1'b0;
    end
  end
  // control registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      unit_r  <= CTRL_RST[C_UNIT +: 2];
      head_r  <= CTRL_RST[C_HEAD +: 4];
      mode_r  <= CTRL_RST[C_MODE +: 2];
      wgq_r   <= CTRL_RST[C_WG];
      rgq_r   <= CTRL_RST[C_RG];
      rec_r   <= CTRL_RST[C_REC];
      tries_r <= 4'h0;
      abn_r   <= 1'b0;
      wfs_r   <= 1'b0;
      ref_r   <= 1'b0;
      rxd_r   <= 8'h00;
      rxv_r   <= 1'b0;
      ack_r   <= 1'b0;
    end else if (CE) begin
      unit_r  <= unit_nxt;
      head_r  <= head_nxt;
      mode_r  <= mode_nxt;
      wgq_r   <= wgq_nxt;
      rgq_r   <= rgq_nxt;
      rec_r   <= rec_nxt;
      tries_r <= tries_nxt;
      abn_r   <= abn_nxt;
      wfs_r   <= wfs_nxt;
      ref_r   <= ref_nxt;
      rxd_r   <= rxd_nxt;
      rxv_r   <= rxv_nxt;
      ack_r   <= ack_nxt;
    end
  end
  // ----------------------------------------------------------------
  // step pulse train
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_SET, ST_HI, ST_LO} ddci_st_t;
  ddci_st_t   st_r, st_nxt;   // train state
  logic [7:0] tm_r, tm_nxt;   // phase timer
  logic [7:0] cnt_r, cnt_nxt; // pulses left
  logic       dir_r, dir_nxt; // latched direction
  assign busy = st_r != ST_IDLE;
  // pulses are issued back to back so buffering drives can merge
  always_comb begin
    st_nxt  = st_r;
    tm_nxt  = tm_r;
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    case (st_r)
      ST_IDLE: if (go) begin // latch train
        st_nxt  = ST_SET;
        tm_nxt  = DIR_SET_CYC - 8'h01;
        cnt_nxt = go_cnt;
        dir_nxt = go_dir;
      end
      ST_SET: if (tm_r == 8'h00) begin // direction settled
        st_nxt = ST_HI;
        tm_nxt = STEP_HI_CYC - 8'h01;
      end else begin
        tm_nxt = tm_r - 8'h01;
      end
      ST_HI: if (tm_r == 8'h00) begin // one pulse per track
        st_nxt  = ST_LO;
        tm_nxt  = STEP_LO_CYC - 8'h01;
        cnt_nxt = cnt_r - 8'h01;
      end else begin
        tm_nxt = tm_r - 8'h01;
      end
      ST_LO: if (tm_r != 8'h00) begin
        tm_nxt = tm_r - 8'h01;
      end else if (cnt_r == 8'h00) begin // train done
        st_nxt = ST_IDLE;
      end else begin
        st_nxt = ST_HI;
        tm_nxt = STEP_HI_CYC - 8'h01;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end
  // train registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r  <= ST_IDLE;
      tm_r  <= 8'h00;
      cnt_r <= 8'h00;
      dir_r <= 1'b0;
    end else if (CE) begin
      st_r  <= st_nxt;
      tm_r  <= tm_nxt;
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
    end
  end
  // ----------------------------------------------------------------
  // serial write data at the variant's fixed rate
  // ----------------------------------------------------------------
  logic [7:0] tsh_r, tsh_nxt; // write shifter
  logic [3:0] tb_r, tb_nxt;   // bits left
  logic [2:0] tc_r, tc_nxt;   // bit period counter
  logic       tick;           // bit boundary
  assign tick = tc_r == 3'h0;
  // one bit per period, msb first, only inside write window
  always_comb begin
    tsh_nxt = tsh_r;
    tb_nxt  = tb_r;
    tc_nxt  = tick ? bit_cyc(mode_r) - 3'h1 : tc_r - 3'h1;
    if (WR && ADDR == A_TXD && tb_r == 4'h0) begin // load, full first bit
      {tsh_nxt, tb_nxt, tc_nxt} =
        {WDATA[7:0], 4'h8, bit_cyc(mode_r) - 3'h1};
    end else if (tick && WRITE_GATE && tb_r != 4'h0) begin
      tsh_nxt = {tsh_r[6:0], 1'b0};
      tb_nxt  = tb_r - 4'h1;
    end
  end
  // write data registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tsh_r <= 8'h00;
      tb_r  <= 4'h0;
      tc_r  <= 3'h0;
    end else if (CE) begin
      tsh_r <= tsh_nxt;
      tb_r  <= tb_nxt;
      tc_r  <= tc_nxt;
    end
  end
  // ----------------------------------------------------------------
  // pins and read data
  // ----------------------------------------------------------------
  logic [15:0] stat; // status word
  assign stat = {2'h0, ref_r, tries_r, tb_r != 4'h0, abn_r, ovr_s,
                 rxv_r, wfs_r, wf_s, sdone_s, ready_s, busy};
  // all pins registered; no serial command lines exist
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DRV_SEL    <= 3'h0;
      STEP       <= 1'b0;
      DIRECTION  <= 1'b0;
      HEAD_SEL   <= 4'h0;
      WRITE_GATE <= 1'b0;
      WRITE_DATA <= 1'b0;
      RECOVERY   <= 1'b0;
      READ_GATE  <= 1'b0;
      RDATA      <= 16'h0000;
    end else if (CE) begin
      DRV_SEL    <= unit_dec(unit_r);
      STEP       <= st_r == ST_HI;
      DIRECTION  <= dir_r;
      HEAD_SEL   <= head_r;
      WRITE_GATE <= wgq_r && wg_ok && !rgq_r;
      WRITE_DATA <= WRITE_GATE && tb_r != 4'h0 && tsh_r[7];
      RECOVERY   <= rec_r && mode_r == MODE_HP;
      READ_GATE  <= rgq_r && mode_r == MODE_SEP && !wgq_r &&
                    unit_r != 2'h0 && ready_s;
      case (ADDR)
        A_CTRL:  RDATA <= {5'h00, rec_r, rgq_r, wgq_r, mode_r,
                           head_r, unit_r};
        A_STAT:  RDATA <= stat;
        A_RXD:   RDATA <= {8'h00, rxd_r};
        default: RDATA <= 16'h0000;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  step_gate_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(STEP) |-> !WRITE_GATE && DRV_SEL != 3'h0)
    else $error("step pulsed without gating");
  dir_steady_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    STEP |-> $stable(DIRECTION) && $past(DIRECTION) == dir_r)
    else $error("direction moved during pulse");
  read_gate_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    READ_GATE |-> !WRITE_GATE && $past(mode_r) == MODE_SEP)
    else $error("read window in wrong state");
  wg_fault_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && wf_s |=> !WRITE_GATE)
    else $error("write window during fault");
  base_rate_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && tick && mode_r == MODE_BASE ##1 CE[*3] ##0 $stable(mode_r)
    |-> $past(!tick) && !tick)
    else $error("base bit period wrong");
  rec_count_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    tries_r <= MAX_TRIES)
    else $error("too many recovery steps");
  rec_abandon_a: assert property (@(posedge CLK)
    disable iff (!RESET_N)
    CE && wr_rec && rec_r && !WDATA[R_OK] && WDATA[R_FAIL] &&
    tries_r == MAX_TRIES |=> !rec_r && abn_r && $past(!go))
    else $error("recovery not abandoned");
  sel_one_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    $onehot0(DRV_SEL))
    else $error("more than one drive chosen");
endmodule : ddci_top

/* File: logic/ddci_pkg.sv */
// constants for the disk drive control interface controller
// assumes a 20 mhz system clock and a plain register port
package ddci_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 20;   // system clock rate
  localparam int STEP_HI_NS  = 1000; // step pulse high time
  localparam int STEP_LO_NS  = 1000; // gap between step pulses
  localparam int DIR_SET_NS  = 500;  // direction settle before step
  localparam int BASE_MBPS   = 5;    // base variant serial rate
  localparam int HP_MBPS     = 10;   // high performance serial rate
  localparam int SEP_MBPS    = 20;   // separator variant, under 24
  localparam logic [7:0] STEP_HI_CYC =
    8'((STEP_HI_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] STEP_LO_CYC =
    8'((STEP_LO_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] DIR_SET_CYC =
    8'((DIR_SET_NS * CLK_MHZ + 999) / 1000);
  localparam logic [2:0] BASE_BIT_CYC = 3'(CLK_MHZ / BASE_MBPS);
  localparam logic [2:0] HP_BIT_CYC   = 3'(CLK_MHZ / HP_MBPS);
  localparam logic [2:0] SEP_BIT_CYC  = 3'(CLK_MHZ / SEP_MBPS);
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] A_CTRL  = 4'h0; // control
  localparam logic [3:0] A_SEEK  = 4'h1; // step train command
  localparam logic [3:0] A_STAT  = 4'h2; // status
  localparam logic [3:0] A_RXD   = 4'h3; // received read byte
  localparam logic [3:0] A_RECOV = 4'h4; // recovery verdict
  localparam logic [3:0] A_TXD   = 4'h5; // write data byte
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int C_UNIT = 0;  // [1:0] unit, 0 none
  localparam int C_HEAD = 2;  // [5:2] head index
  localparam int C_MODE = 6;  // [7:6] interface variant
  localparam int C_WG   = 8;  // write window request
  localparam int C_RG   = 9;  // read window request
  localparam int C_REC  = 10; // recovery mode request
  localparam int S_DIR  = 15; // seek direction, 1 outward
  localparam int R_FAIL = 0;  // reread failed
  localparam int R_OK   = 1;  // reread succeeded
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [1:0] MODE_BASE = 2'h0;
  localparam logic [1:0] MODE_HP   = 2'h1;
  localparam logic [1:0] MODE_SEP  = 2'h2;
  localparam logic [3:0] MAX_TRIES = 4'h8;
endpackage : ddci_pkg

/* File: logic/ddci_sync.sv */
// two flip-flop synchroniser, one chain per bit
// assumes d comes from another clock domain or a pin
module ddci_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // ----------------------------------------------------------------
  // per bit chains
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_r; // first stage, read only by second
      // two stage chain
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r <= 1'b0;
          q[i] <= 1'b0;
        end else if (en) begin
          s1_r <= d[i];
          q[i] <= s1_r;
        end
      end
    end
  endgenerate
endmodule : ddci_sync

/* File: logic/ddci_rx.sv */
// read data deserialiser on the drive's read clock
// assumes nrz data valid at the rising read clock edge
module ddci_rx
  import ddci_pkg::*;
(
  input  wire logic       rd_clk,
  input  wire logic       rst_n,
  input  wire logic       nrz,
  input  wire logic       gate,
  input  wire logic       ack_tgl,
  output logic [7:0]      hold_r,
  output logic            req_r,
  output logic            ovr_r
);
  // ----------------------------------------------------------------
  // crossings into the link domain
  // ----------------------------------------------------------------
  logic g_s;    // read window, link side
  logic a_s;    // acknowledge toggle, link side
  logic lrst_n; // frame reset: read clock may stop once window closes
  assign lrst_n = rst_n & gate;
  ddci_sync #(.W(2)) u_sync (
    .clk   (rd_clk),
    .rst_n (lrst_n),
    .en    (1'b1),
    .d     ({gate, ack_tgl}),
    .q     ({g_s, a_s})
  );
  // ----------------------------------------------------------------
  // shifter and handshake
  // ----------------------------------------------------------------
  logic [7:0] sh_r, sh_nxt;     // shift register
  logic [2:0] bits_r, bits_nxt; // bits gathered
  logic [7:0] hold_nxt;
  logic       req_nxt, ovr_nxt;
  // timing taken from drive clock only
  always_comb begin
    sh_nxt   = sh_r;
    bits_nxt = bits_r;
    hold_nxt = hold_r;
    req_nxt  = req_r;
    ovr_nxt  = ovr_r;
    if (!g_s) begin // window closed, realign
      bits_nxt = 3'h0;
      ovr_nxt  = 1'b0;
    end else begin
      sh_nxt   = {sh_r[6:0], nrz};
      bits_nxt = bits_r + 3'h1;
      if (bits_r == 3'h7) begin
        if (req_r == a_s) begin // last byte taken
          hold_nxt = {sh_r[6:0], nrz};
          req_nxt  = ~req_r;
        end else begin // byte lost
          ovr_nxt = 1'b1;
        end
      end
    end
  end
  // frame registers, cleared whenever the window closes
  always_ff @(posedge rd_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      sh_r   <= 8'h00;
      bits_r <= 3'h0;
      ovr_r  <= 1'b0;
    end else begin
      sh_r   <= sh_nxt;
      bits_r <= bits_nxt;
      ovr_r  <= ovr_nxt;
    end
  end
  // handshake registers, kept across frames
  always_ff @(posedge rd_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= 8'h00;
      req_r  <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
      req_r  <= req_nxt;
    end
  end
endmodule : ddci_rx

/* File: verif/ddci_drive_model.sv */
// behavioural drive on the far side of the controller
// assumes it is wired as unit 1 and the bench owns the fault
module ddci_drive_model #(
  parameter logic [7:0] PAT = 8'hb4
) (
  input  wire logic       sel,
  input  wire logic       step,
  input  wire logic       dir,
  input  wire logic [3:0] head_sel,
  input  wire logic       rgate,
  input  wire logic       fault,
  output logic            ready,
  output logic            sdone,
  output logic            wfault,
  output logic            rclk,
  output logic            nrz,
  output int              trk,
  output logic [3:0]      head
);
  timeunit 1ns;
  timeprecision 100ps;
  int bit_i; // next pattern bit
  // ------------------------------------------------------------
  // status lines, driven only while chosen
  // ------------------------------------------------------------
  assign ready  = sel;
  assign sdone  = sel;
  assign wfault = sel & fault;
  assign head   = sel ? head_sel : 4'h0;
  // ------------------------------------------------------------
  // head motion: one track per pulse, no buffering
  // ------------------------------------------------------------
  initial trk = 0;
  always @(posedge step) begin
    if (sel) trk = dir ? trk - 1 : trk + 1;
  end
  // ------------------------------------------------------------
  // read clock runs only in a frame; data changes on falling edge
  // ------------------------------------------------------------
  initial begin
    rclk  = 1'b0;
    nrz   = 1'b0;
    bit_i = 0;
    #1.7;
    forever begin
      #3;
      if (rgate && sel) begin
        rclk = ~rclk;
        if (!rclk) begin
          nrz   = PAT[7-bit_i];
          bit_i = (bit_i + 1) % 8;
        end
      end else begin
        // idle: clock still, data line meaningless
        rclk = 1'b0;
        nrz  = ~nrz;
      end
    end
  end
endmodule : ddci_drive_model

/* File: verif/ddci_top_tb.sv */
// self-checking bench for the disk drive controller
// assumes one drive model on unit 1 and a register port master
module ddci_top_tb
  import ddci_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] RPAT = 8'hb4; // byte the drive serves
  logic        CLK = 1'b0, RESET_N = 1'b0, WR = 1'b0, RD = 1'b0, CE = 1'b1;
  logic [7:0]  tx; // random write byte
  logic [3:0]  ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic [15:0] RDATA, v;
  logic        READY, SEEK_DONE, WRITE_FAULT, RD_CLK, RD_NRZ;
  logic        STEP, DIRECTION, WRITE_GATE, WRITE_DATA;
  logic        RECOVERY, READ_GATE, ok, ldir, fault = 1'b0;
  logic [2:0]  DRV_SEL;
  logic [3:0]  HEAD_SEL, head, hd;
  int          trk, exp_trk, err_total, tests_run;
  always #25 CLK = ~CLK; // 20 mhz
  ddci_top dut (.CLK(CLK), .RESET_N(RESET_N), .CE(CE), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .READY(READY),
    .SEEK_DONE(SEEK_DONE), .WRITE_FAULT(WRITE_FAULT), .RD_CLK(RD_CLK),
    .RD_NRZ(RD_NRZ), .DRV_SEL(DRV_SEL), .STEP(STEP),
    .DIRECTION(DIRECTION), .HEAD_SEL(HEAD_SEL), .WRITE_GATE(WRITE_GATE),
    .WRITE_DATA(WRITE_DATA), .RECOVERY(RECOVERY), .READ_GATE(READ_GATE));
  ddci_drive_model #(.PAT(RPAT)) drv (.sel(DRV_SEL[0]), .step(STEP),
    .dir(DIRECTION), .head_sel(HEAD_SEL), .rgate(READ_GATE),
    .fault(fault), .ready(READY), .sdone(SEEK_DONE),
    .wfault(WRITE_FAULT), .rclk(RD_CLK), .nrz(RD_NRZ), .trk(trk),
    .head(head));
  // ------------------------------------------------------------
  // compare, report, bus cycles
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD   <= 1'b0;
    #1 v = RDATA; // data stand one cycle only
  endtask : rd
  // bounded poll of one status bit
  task automatic poll(input int b, input logic want);
    int n;
    n = 0;
    do begin
      rd(A_STAT);
      n++;
    end while (v[b] !== want && n < 400);
    if (v[b] !== want) begin
      chk("wait bound", 16'h0000, 16'h0001);
      stop_test();
    end
  endtask : poll
  // seek n tracks, model track count must follow
  task automatic seek(input int n, input logic d);
    wr(A_SEEK, {d, 7'h00, 8'(n)});
    ldir = d;
    exp_trk = d ? exp_trk - n : exp_trk + n;
    poll(0, 1'b0);
    chk("track", 16'(exp_trk), 16'(trk));
    chk("direction", {15'h0, d}, {15'h0, DIRECTION});
  endtask : seek
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h7b07a712));
    err_total = 0;
    tests_run = 0;
    exp_trk   = 0;
    repeat (5) @(posedge CLK);
    RESET_N <= 1'b1;
    rd(A_CTRL);
    chk("ctrl reset", CTRL_RST, v);
    chk("select idle", 16'h0000, {13'h0, DRV_SEL});
    // seek with no unit chosen is refused
    wr(A_SEEK, 16'h0001);
    rd(A_STAT);
    chk("refused no unit", 16'h0001, {15'h0, v[13]});
    hd = 4'($urandom_range(15));
    wr(A_CTRL, {10'h000, hd, 2'h1});
    repeat (3) @(posedge CLK);
    chk("select", 16'h0001, {13'h0, DRV_SEL});
    chk("head", {12'h0, hd}, {12'h0, head});
    // a write while the clock enable is low must be lost
    CE <= 1'b0;
    wr(A_CTRL, 16'h0000);
    CE <= 1'b1;
    rd(A_CTRL);
    chk("frozen", {10'h000, hd, 2'h1}, v);
    // random trains, both senses
    for (int i = 0; i < 4; i++) seek($urandom_range(1, 5), i[0]);
    // count zero refused, no motion
    wr(A_SEEK, 16'h8000);
    rd(A_STAT);
    chk("refused zero", 16'h0001, {15'h0, v[13]});
    chk("no motion", 16'(exp_trk), 16'(trk));
    // write window held off by a fault, then opened
    fault <= 1'b1;
    wr(A_CTRL, {7'h00, 1'b1, 2'h0, hd, 2'h1});
    repeat (5) @(posedge CLK);
    chk("gate on fault", 16'h0000, {15'h0, WRITE_GATE});
    fault <= 1'b0;
    repeat (5) @(posedge CLK);
    chk("write gate", 16'h0001, {15'h0, WRITE_GATE});
    tx = 8'($urandom_range(255));
    wr(A_TXD, {8'h00, tx});
    rd(A_STAT);
    chk("tx busy", 16'h0001, {15'h0, v[8]});
    // one bit per four clocks, msb first, sampled mid bit
    for (int k = 7; k >= 0; k--) begin
      repeat ((k == 7) ? 1 : 4) @(posedge CLK);
      chk("write bit", {15'h0, tx[k]}, {15'h0, WRITE_DATA});
    end
    poll(8, 1'b0);
    wr(A_SEEK, 16'h0001);
    rd(A_STAT);
    chk("refused gated", 16'h0001, {15'h0, v[13]});
    // recovery: eight micro steps then abandon
    wr(A_CTRL, {5'h00, 1'b1, 2'h0, MODE_HP, hd, 2'h1});
    repeat (3) @(posedge CLK);
    chk("recovery line", 16'h0001, {15'h0, RECOVERY});
    for (int i = 0; i < 8; i++) begin
      wr(A_RECOV, 16'h0001);
      exp_trk = ldir ? exp_trk - 1 : exp_trk + 1;
      poll(0, 1'b0);
    end
    chk("micro steps", 16'(exp_trk), 16'(trk));
    rd(A_STAT);
    chk("tries", {12'h0, MAX_TRIES}, {12'h0, v[12:9]});
    wr(A_RECOV, 16'h0001);
    repeat (3) @(posedge CLK);
    rd(A_STAT);
    chk("abandoned", 16'h0001, {15'h0, v[7]});
    chk("recovery off", 16'h0000, {15'h0, RECOVERY});
    chk("no ninth", 16'(exp_trk), 16'(trk));
    // separator variant: read window and nrz byte
    wr(A_CTRL, {6'h00, 1'b1, 1'b0, MODE_SEP, hd, 2'h1});
    repeat (3) @(posedge CLK);
    chk("read gate", 16'h0001, {15'h0, READ_GATE});
    poll(5, 1'b1);
    rd(A_RXD);
    ok = 1'b0;
    for (int r = 0; r < 8; r++) begin
      if (v[7:0] === 8'({RPAT, RPAT} >> r)) ok = 1'b1;
    end
    chk("read byte", 16'h0001, {15'h0, ok});
    wr(A_CTRL, {10'h000, hd, 2'h1});
    repeat (3) @(posedge CLK);
    chk("read gate off", 16'h0000, {15'h0, READ_GATE});
    stop_test();
  end
endmodule : ddci_top_tb
